// file: hw/clkgen_pkg.sv
// Constants and carrier types for the clock generator serial control block
package clkgen_pkg;

  // Target address, 7 bits; write byte is D2, read byte is D3
  localparam logic [6:0] TARGET_ADDR    = 7'h69;

  // Register indices
  localparam logic [7:0] IDX_PLL        = 8'h00;
  localparam logic [7:0] IDX_SPREAD     = 8'h01;
  localparam logic [7:0] IDX_COUNT      = 8'h08;

  // Reset values
  localparam logic [7:0] PLL_RESET      = 8'hEF;
  localparam logic [7:0] SPREAD_RESET   = 8'hC0;
  localparam logic [7:0] COUNT_RESET    = 8'h09;

  // Writable bit masks, reserved bits cleared
  localparam logic [7:0] PLL_MASK       = 8'hEF;
  localparam logic [7:0] SPREAD_MASK    = 8'hF8;

  // Field positions in the PLL and divider register
  localparam int MAIN_PLL_BIT     = 7;
  localparam int DISPLAY_PLL_BIT  = 6;
  localparam int PANEL_PLL_BIT    = 5;
  localparam int CPU_DIV_BIT      = 3;
  localparam int PERIPH_DIV_BIT   = 2;
  localparam int PANEL_DIV_BIT    = 1;
  localparam int DISPLAY_DIV_BIT  = 0;

  // Field positions in the spread register
  localparam int MAIN_SS_BIT      = 7;
  localparam int PANEL_SS_BIT     = 6;
  localparam int SEL_HI           = 5;
  localparam int SEL_LO           = 3;
  localparam int CENTER_BIT       = 5;

  // Bit count of one byte on the wire
  localparam logic [3:0] BYTE_BITS      = 4'h8;

  // Synchronised line levels and events
  typedef struct packed {
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
  } line_ev_t;

  // PLL and divider enables toward the analog core
  typedef struct packed {
    logic main_pll_enable;
    logic display_pll_enable;
    logic panel_pll_enable;
    logic cpu_divider_enable;
    logic periph_ref_divider_enable;
    logic panel_divider_enable;
    logic display_divider_enable;
  } pll_ctrl_t;

  // Spread settings toward the analog core
  typedef struct packed {
    logic       main_spread_enable;
    logic       panel_spread_enable;
    logic [2:0] panel_spread_select;
    logic       panel_center_spread;
  } spread_ctrl_t;

endpackage

// file: hw/line_sync.sv
// Three-stage synchroniser and event detector for the serial bus lines
`timescale 1ns/10ps
`default_nettype none

module line_sync
(
  input  wire logic                clock,
  input  wire logic                nrst,
  input  wire logic                scl_in,
  input  wire logic                sda_in,
  output var clkgen_pkg::line_ev_t ev
);

  logic [1:0] scl_m_q;   // First stages, read only by second
  logic [1:0] scl_s_q;   // Third stage and previous sample
  logic [1:0] sda_m_q;   // First stages, read only by second
  logic [1:0] sda_s_q;   // Third stage and previous sample

  ////////////////////////////////////////////////////////////////////////////
  // Synchroniser chains; lines idle high
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      scl_m_q <= 2'h3;
      scl_s_q <= 2'h3;
      sda_m_q <= 2'h3;
      sda_s_q <= 2'h3;
    end
    else
    begin
      scl_m_q <= {scl_m_q[0], scl_in};
      sda_m_q <= {sda_m_q[0], sda_in};
      scl_s_q <= {scl_s_q[0], scl_m_q[1]};
      sda_s_q <= {sda_s_q[0], sda_m_q[1]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Events from the settled samples only
  assign ev.scl      = scl_s_q[0];
  assign ev.sda      = sda_s_q[0];
  assign ev.scl_rise = scl_s_q[0] & ~scl_s_q[1];
  assign ev.scl_fall = ~scl_s_q[0] & scl_s_q[1];
  assign ev.start    = scl_s_q[0] & scl_s_q[1] & sda_s_q[1] & ~sda_s_q[0];
  assign ev.stop     = scl_s_q[0] & scl_s_q[1] & ~sda_s_q[1] & sda_s_q[0];

endmodule

`default_nettype wire

// file: hw/clkgen_ctrl.sv
// Serial control target with PLL, divider and spread registers
`timescale 1ns/10ps
`default_nettype none

module clkgen_ctrl
(
  input  wire logic                 clock,
  input  wire logic                 nrst,
  input  wire logic                 scl_in,
  input  wire logic                 sda_in,
  output var  logic                 sda_out,
  output var  logic                 sda_oe,
  output var  clkgen_pkg::pll_ctrl_t    pll,
  output var  clkgen_pkg::spread_ctrl_t spread
);

  typedef enum logic [2:0] {st_idle, st_rx, st_ack, st_tx, st_rack} state_t;

  clkgen_pkg::line_ev_t ev;        // Synchronised line events
  state_t               st_q;      // Transfer state
  logic [3:0]           bit_q;     // Bits moved in current byte
  logic [1:0]           byte_q;    // Byte number, saturates at 3
  logic [7:0]           sh_q;      // Shift register, both directions
  logic [7:0]           idx_q;     // Register index pointer
  logic                 rw_q;      // Read transfer selected
  logic                 first_q;   // Next sent byte is the count
  logic [7:0]           pll_q;     // PLL and divider register
  logic [7:0]           ss_q;      // Spread register
  logic [7:0]           cnt_q;     // Read byte count register
  logic                 cnt_wr_q;  // Count was written
  logic                 oe_q;      // Pull data line low
  logic                 out_q;     // Driven level, always low
  clkgen_pkg::pll_ctrl_t    pll_q_o;   // Registered PLL outputs
  clkgen_pkg::spread_ctrl_t ss_q_o;    // Registered spread outputs

  ////////////////////////////////////////////////////////////////////////////
  // Line synchroniser
  line_sync u_sync
  (
    .clock  (clock),
    .nrst   (nrst),
    .scl_in (scl_in),
    .sda_in (sda_in),
    .ev     (ev)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Decode of byte completion and register access
  logic       byte_done;   // Eighth bit in, clock falling
  logic       addr_hit;    // Address byte matches
  logic       wr_data;     // Data byte to store
  logic [7:0] rd_byte;     // Register read mux
  logic [7:0] pll_w;       // PLL write value after forcing
  logic [7:0] next_tx;     // Next byte to send
  logic [7:0] rd_start;    // Index where a read begins

  assign byte_done = (st_q == st_rx) && ev.scl_fall
                     && (bit_q == clkgen_pkg::BYTE_BITS);
  assign addr_hit  = sh_q[7:1] == clkgen_pkg::TARGET_ADDR;
  assign wr_data   = byte_done && (byte_q == 2'h3);

  // Unmapped indices read zero
  assign rd_byte = (idx_q == clkgen_pkg::IDX_PLL)    ? pll_q :
                   (idx_q == clkgen_pkg::IDX_SPREAD) ? ss_q :
                   (idx_q == clkgen_pkg::IDX_COUNT)  ? cnt_q : 8'h00;

  // Count first, then register bytes
  assign next_tx  = first_q ? cnt_q : rd_byte;
  assign rd_start = cnt_wr_q ? 8'h00 : idx_q;

  // Divider enables forced off with their PLL
  always_comb
  begin
    pll_w = sh_q & clkgen_pkg::PLL_MASK;
    if (!pll_w[clkgen_pkg::MAIN_PLL_BIT])
    begin
      pll_w[clkgen_pkg::CPU_DIV_BIT]    = 1'b0;
      pll_w[clkgen_pkg::PERIPH_DIV_BIT] = 1'b0;
    end
    if (!pll_w[clkgen_pkg::PANEL_PLL_BIT])
    begin
      pll_w[clkgen_pkg::PANEL_DIV_BIT] = 1'b0;
    end
    if (!pll_w[clkgen_pkg::DISPLAY_PLL_BIT])
    begin
      pll_w[clkgen_pkg::DISPLAY_DIV_BIT] = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transfer state machine
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      st_q    <= st_idle;
      bit_q   <= 4'h0;
      byte_q  <= 2'h0;
      sh_q    <= 8'h00;
      idx_q   <= 8'h00;
      rw_q    <= 1'b0;
      first_q <= 1'b0;
      oe_q    <= 1'b0;
    end
    else if (ev.stop)
    begin
      // Stop ends any transfer
      st_q <= st_idle;
      oe_q <= 1'b0;
    end
    else if (ev.start)
    begin
      // Start or repeated start
      st_q   <= st_rx;
      bit_q  <= 4'h0;
      byte_q <= 2'h0;
      oe_q   <= 1'b0;
    end
    else
    begin
      case (st_q)
        st_rx:
        begin
          if (ev.scl_rise)
          begin
            // Sample data bit
            sh_q  <= {sh_q[6:0], ev.sda};
            bit_q <= bit_q + 4'h1;
          end
          else if (byte_done)
          begin
            if (byte_q == 2'h0)
            begin
              if (addr_hit)
              begin
                // Own address, acknowledge
                st_q    <= st_ack;
                oe_q    <= 1'b1;
                rw_q    <= sh_q[0];
                first_q <= sh_q[0];
                if (sh_q[0])
                begin
                  idx_q <= rd_start;
                end
              end
              else
              begin
                st_q <= st_idle;
              end
            end
            else
            begin
              // Index, count or data byte
              st_q <= st_ack;
              oe_q <= 1'b1;
              if (byte_q == 2'h1)
              begin
                idx_q <= sh_q;
              end
              else if (byte_q == 2'h3)
              begin
                idx_q <= idx_q + 8'h01;
              end
            end
            if (byte_q != 2'h3)
            begin
              byte_q <= byte_q + 2'h1;
            end
          end
        end
        st_ack:
        begin
          if (ev.scl_fall)
          begin
            bit_q <= 4'h0;
            if (rw_q)
            begin
              // First bit of the count byte
              st_q    <= st_tx;
              sh_q    <= {next_tx[6:0], 1'b0};
              oe_q    <= ~next_tx[7];
              bit_q   <= 4'h1;
              first_q <= 1'b0;
            end
            else
            begin
              st_q <= st_rx;
              oe_q <= 1'b0;
            end
          end
        end
        st_tx:
        begin
          if (ev.scl_fall)
          begin
            if (bit_q == clkgen_pkg::BYTE_BITS)
            begin
              // Release for the host answer
              st_q <= st_rack;
              oe_q <= 1'b0;
            end
            else
            begin
              oe_q  <= ~sh_q[7];
              sh_q  <= {sh_q[6:0], 1'b0};
              bit_q <= bit_q + 4'h1;
            end
          end
        end
        st_rack:
        begin
          if (ev.scl_rise && ev.sda)
          begin
            // Not-acknowledge ends the read
            st_q <= st_idle;
          end
          else if (ev.scl_fall)
          begin
            // Acknowledge, send next byte
            st_q    <= st_tx;
            sh_q    <= {next_tx[6:0], 1'b0};
            oe_q    <= ~next_tx[7];
            bit_q   <= 4'h1;
            first_q <= 1'b0;
            if (!first_q)
            begin
              idx_q <= idx_q + 8'h01;
            end
          end
        end
        default:
        begin
          oe_q <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file writes
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      pll_q    <= clkgen_pkg::PLL_RESET;
      ss_q     <= clkgen_pkg::SPREAD_RESET;
      cnt_q    <= clkgen_pkg::COUNT_RESET;
      cnt_wr_q <= 1'b0;
    end
    else if (wr_data)
    begin
      if (idx_q == clkgen_pkg::IDX_PLL)
      begin
        pll_q <= pll_w;
      end
      else if (idx_q == clkgen_pkg::IDX_SPREAD)
      begin
        ss_q <= sh_q & clkgen_pkg::SPREAD_MASK;
      end
      else if (idx_q == clkgen_pkg::IDX_COUNT)
      begin
        cnt_q    <= sh_q;
        cnt_wr_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs toward the core
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      pll_q_o <= '0;
      ss_q_o  <= '0;
      out_q   <= 1'b0;
    end
    else
    begin
      pll_q_o.main_pll_enable           <= pll_q[clkgen_pkg::MAIN_PLL_BIT];
      pll_q_o.display_pll_enable        <= pll_q[clkgen_pkg::DISPLAY_PLL_BIT];
      pll_q_o.panel_pll_enable          <= pll_q[clkgen_pkg::PANEL_PLL_BIT];
      pll_q_o.cpu_divider_enable        <= pll_q[clkgen_pkg::CPU_DIV_BIT];
      pll_q_o.periph_ref_divider_enable <= pll_q[clkgen_pkg::PERIPH_DIV_BIT];
      pll_q_o.panel_divider_enable      <= pll_q[clkgen_pkg::PANEL_DIV_BIT];
      pll_q_o.display_divider_enable    <= pll_q[clkgen_pkg::DISPLAY_DIV_BIT];
      ss_q_o.main_spread_enable  <= ss_q[clkgen_pkg::MAIN_SS_BIT];
      ss_q_o.panel_spread_enable <= ss_q[clkgen_pkg::PANEL_SS_BIT];
      ss_q_o.panel_spread_select <= ss_q[clkgen_pkg::SEL_HI:clkgen_pkg::SEL_LO];
      ss_q_o.panel_center_spread <= ss_q[clkgen_pkg::PANEL_SS_BIT]
                                  & ss_q[clkgen_pkg::CENTER_BIT];
      out_q <= 1'b0;
    end
  end

  assign sda_oe  = oe_q;
  assign sda_out = out_q;
  assign pll     = pll_q_o;
  assign spread  = ss_q_o;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  property p_cpu_div;
    pll_q[clkgen_pkg::CPU_DIV_BIT] |-> pll_q[clkgen_pkg::MAIN_PLL_BIT];
  endproperty
  a_cpu_div: assert property (p_cpu_div) else $error("cpu divider on");

  property p_periph_div;
    pll_q[clkgen_pkg::PERIPH_DIV_BIT] |-> pll_q[clkgen_pkg::MAIN_PLL_BIT];
  endproperty
  a_periph_div: assert property (p_periph_div) else $error("periph div on");

  property p_panel_div;
    ##1 pll_q_o.panel_divider_enable |-> pll_q_o.panel_pll_enable;
  endproperty
  a_panel_div: assert property (p_panel_div) else $error("panel div on");

  property p_disp_div;
    pll_q[clkgen_pkg::DISPLAY_DIV_BIT] |-> pll_q[clkgen_pkg::DISPLAY_PLL_BIT];
  endproperty
  a_disp_div: assert property (p_disp_div) else $error("display div on");

  property p_reserved;
    (pll_q & ~clkgen_pkg::PLL_MASK) == 8'h00
      && (ss_q & ~clkgen_pkg::SPREAD_MASK) == 8'h00;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit set");

  property p_addr_ack;
    (byte_done && byte_q == 2'h0 && addr_hit) |=> oe_q && st_q == st_ack;
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("no address ack");

  property p_nack_release;
    (st_q == st_rack && ev.scl_rise && ev.sda && !ev.stop && !ev.start)
      |=> !oe_q && st_q == st_idle;
  endproperty
  a_nack_release: assert property (p_nack_release) else $error("no release");

  property p_count_first;
    (st_q == st_ack && ev.scl_fall && rw_q && !ev.stop && !ev.start)
      |=> oe_q == ~$past(cnt_q[7]);
  endproperty
  a_count_first: assert property (p_count_first) else $error("count not first");

  property p_read_zero;
    (byte_done && byte_q == 2'h0 && addr_hit && sh_q[0] && cnt_wr_q)
      |=> idx_q == 8'h00;
  endproperty
  a_read_zero: assert property (p_read_zero) else $error("read not at zero");

  property p_wr_step;
    (wr_data && !ev.stop && !ev.start) |=> idx_q == $past(idx_q) + 8'h01;
  endproperty
  a_wr_step: assert property (p_wr_step) else $error("index not stepped");

  property p_drive_states;
    oe_q |-> (st_q == st_ack || st_q == st_tx);
  endproperty
  a_drive_states: assert property (p_drive_states) else $error("stray drive");

  c_read_end:  cover property (st_q == st_rack ##1 st_q == st_idle);
  c_write:     cover property (wr_data && idx_q == clkgen_pkg::IDX_PLL);
  c_cnt_write: cover property (wr_data && idx_q == clkgen_pkg::IDX_COUNT);

endmodule

`default_nettype wire

// file: verification/smbus_host_model.sv
// Behavioural bus host issuing block writes and block reads
`timescale 1ns/10ps
`default_nettype none

module smbus_host_model
(
  input  wire logic clock,
  input  wire logic sda_wire,
  output var  logic scl,
  output var  logic sda
);
  logic [7:0] rd_q [0:3]; // Bytes of the last read, count first
  logic       released;   // Line level after the host nack
  logic       ack_all;    // Every device ack seen in last transfer

  initial
  begin
    scl = 1'b1;
    sda = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////
  // Wait whole clock periods, always landing on a falling edge
  task automatic hw(input int n);
    repeat (n) @(negedge clock);
  endtask

  // One bit slot; phases of 8 clocks, data set well after scl falls
  task automatic bit_io(input logic b, output logic r);
    hw(4);
    sda = b;
    hw(8);
    scl = 1'b1;
    hw(8);
    r = sda_wire;
    scl = 1'b0;
  endtask

  // Start or repeated start: data falls while scl is high
  task automatic start;
    hw(4);
    sda = 1'b1;
    hw(8);
    scl = 1'b1;
    hw(8);
    sda = 1'b0;
    hw(8);
    scl = 1'b0;
  endtask

  // Stop: data rises while scl is high
  task automatic stop;
    hw(4);
    sda = 1'b0;
    hw(8);
    scl = 1'b1;
    hw(8);
    sda = 1'b1;
    hw(8);
  endtask

  // Byte out MSB first, then release for the device ack
  task automatic put(input logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(b[i], r);
    bit_io(1'b1, r);
    if (r)
      ack_all = 1'b0;
  endtask

  // Byte in; ack unless last, then nack and look at the line
  task automatic get(input logic last, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(1'b1, r);
      b[i] = r;
    end
    bit_io(last, r);
    hw(6);
    released = sda_wire;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Address alone, to see whether anything answers
  task automatic probe(input logic [7:0] a);
    ack_all = 1'b1;
    start();
    put(a);
    stop();
  endtask

  // Block write of n bytes taken from the top of w
  task automatic write_blk(input logic [7:0] idx, input logic [31:0] w,
                           input int n);
    ack_all = 1'b1;
    start();
    put({clkgen_pkg::TARGET_ADDR, 1'b0});
    put(idx);
    put(8'(n));
    for (int k = 0; k < n; k++)
      put(w[31 - 8 * k -: 8]);
    stop();
  endtask

  // Block read: count byte plus n data bytes, last one refused
  task automatic read_blk(input logic [7:0] idx, input int n);
    ack_all = 1'b1;
    start();
    put({clkgen_pkg::TARGET_ADDR, 1'b0});
    put(idx);
    start();
    put({clkgen_pkg::TARGET_ADDR, 1'b1});
    for (int k = 0; k <= n; k++)
      get(k == n, rd_q[k]);
    stop();
  endtask
endmodule

`default_nettype wire

// file: verification/clkgen_ctrl_tb_top.sv
// Self-checking bench for the clock generator serial control block
`timescale 1ns/10ps
`default_nettype none

module clkgen_ctrl_tb_top;
  logic                     clock;       // 25 MHz bench clock
  logic                     nrst;        // Synchronous reset, low active
  logic                     scl;         // Host clock line
  logic                     sda_h;       // Host data drive, 1 = release
  logic                     sda_out;     // Device data level, not on the wire
  logic                     sda_oe;      // Device pulls data low
  wire  logic               sda_wire;    // Resolved data line
  clkgen_pkg::pll_ctrl_t    pll;         // PLL and divider enables
  clkgen_pkg::spread_ctrl_t spread;      // Spread settings
  int                       n_fail;      // Mismatch count
  int                       checks_done; // Comparison count
  int                       cycles;      // Cycle count for the watchdog
  logic [7:0]               w0;          // Value written to register 0
  logic [7:0]               w1;          // Value written to register 1

  // Open drain with pull-up: low if either side pulls
  assign sda_wire = sda_h & ~sda_oe;

  clkgen_ctrl dut_u
  (
    .clock   (clock),
    .nrst    (nrst),
    .scl_in  (scl),
    .sda_in  (sda_wire),
    .sda_out (sda_out),
    .sda_oe  (sda_oe),
    .pll     (pll),
    .spread  (spread)
  );

  smbus_host_model host_u
  (
    .clock    (clock),
    .sda_wire (sda_wire),
    .scl      (scl),
    .sda      (sda_h)
  );

  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  ////////////////////////////////////////////////////////////////////////
  // Register 0 after masking and divider forcing
  function automatic logic [7:0] exp_r0(input logic [7:0] d);
    logic [7:0] m;
    m = d & clkgen_pkg::PLL_MASK;
    if (!m[7])
      m[3:2] = 2'b00;
    if (!m[5])
      m[1] = 1'b0;
    if (!m[6])
      m[0] = 1'b0;
    return m;
  endfunction

  // Compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Output pins against register images
  task automatic check_out(input logic [7:0] r0, input logic [7:0] r1);
    repeat (4) @(negedge clock);
    chk({1'b0, pll}, {1'b0, r0[7:5], r0[3:0]});
    chk({2'b00, spread}, {2'b00, r1[7:3], r1[6] & r1[5]});
  endtask

  // Counts, verdict and end of run
  task automatic stop_test;
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Watchdog against a hung transfer
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 80000)
    begin
      n_fail++;
      stop_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    nrst = 1'b0;
    n_fail = 0;
    checks_done = 0;
    cycles = 0;
    void'($urandom(8));
    repeat (6) @(negedge clock);
    nrst = 1'b1;
    check_out(8'hEF, 8'hC0);
    host_u.read_blk(8'h00, 2);
    chk(host_u.rd_q[0], clkgen_pkg::COUNT_RESET);
    chk(host_u.rd_q[1], 8'hEF);
    chk(host_u.rd_q[2], 8'hC0);
    chk({7'h00, host_u.ack_all}, 8'h01);
    chk({7'h00, host_u.released}, 8'h01);
    host_u.probe(8'hA0);
    chk({7'h00, host_u.ack_all}, 8'h00);
    // Corner values first, then random ones
    for (int i = 0; i < 10; i++)
    begin
      w0 = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : (i == 2) ? 8'h5F : 8'($urandom);
      w1 = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom);
      host_u.write_blk(8'h00, {w0, w1, 16'h0000}, 2);
      chk({7'h00, host_u.ack_all}, 8'h01);
      check_out(exp_r0(w0), w1 & clkgen_pkg::SPREAD_MASK);
      host_u.read_blk(8'(i % 2), 2);
      if (i % 2 == 0)
        chk(host_u.rd_q[1], exp_r0(w0));
      else
        chk(host_u.rd_q[2], 8'h00);
      chk(host_u.rd_q[2 - i % 2], w1 & clkgen_pkg::SPREAD_MASK);
    end
    // Open-drain level never driven high
    chk({7'h00, sda_out}, 8'h00);
    // Mid-run reset restores defaults
    nrst = 1'b0;
    repeat (6) @(negedge clock);
    nrst = 1'b1;
    check_out(8'hEF, 8'hC0);
    // Written count makes reads start at index 0
    host_u.write_blk(clkgen_pkg::IDX_COUNT, {8'h02, 24'h000000}, 1);
    host_u.read_blk(8'h01, 2);
    chk(host_u.rd_q[0], 8'h02);
    chk(host_u.rd_q[1], 8'hEF);
    stop_test();
  end
endmodule

`default_nettype wire
